// ---- design/sas_map.svh ----
// Purpose: constants for the sar converter sequencer
// Assumes: 250 MHz core clock, 4 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// clock period of i_clk
`define SAS_CLK_NS 4
// one whole conversion, sample plus eight steps
`define SAS_CONV_NS 7500
// sampling window at the head of a conversion
`define SAS_SAMPLE_NS 1100
// longest time, so rounded down
`define SAS_CONV_CYC (`SAS_CONV_NS / `SAS_CLK_NS)
`define SAS_SAMPLE_CYC (`SAS_SAMPLE_NS / `SAS_CLK_NS)
// result width and approximation steps
`define SAS_RES_W 8
`define SAS_MSB_IDX 3'h7
`define SAS_MSB_MASK 8'h80
// channel count and reset values
`define SAS_NUM_CH 8
`define SAS_CHAN_RST 3'h0
`define SAS_DATA_RST 8'h00

`endif

// ---- design/sas_pkg.sv ----
// Purpose: types shared by the sar converter sequencer
// Assumes: sas_map.svh holds all numbers
// Notes: mode fields arrive as plain inputs, no bus
package sas_pkg;

   // converter mode fields
   typedef struct packed {
      logic run;
      logic hw_start;
      logic scan;
      logic [2:0] chan;
   } sas_mode_t;

   // one finished result with its source channel
   typedef struct packed {
      logic [2:0] chan;
      logic [7:0] data;
   } sas_result_t;

   // sequencer states
   typedef enum logic [1:0] {
      SAS_IDLE,
      SAS_SAMPLE,
      SAS_STEP
   } sas_state_t;

endpackage

// ---- design/sas_adc_seq.sv ----
// Purpose: sequencer for an 8-bit sar converter, eight inputs
// Assumes: comparator output synchronous to i_clk
// Notes: mode fields are plain inputs, result is registered
//
// How it works
// - one of eight analog inputs is routed through the multiplexer per conversion.
// - each result comes from successive approximation against the comparator.
// - every finished value is stored, with its channel, in the 11-bit result register.
// - one conversion lasts about 7.5 us, sample plus eight steps.
// - with hardware start chosen, a trigger rising edge begins conversion.
// - with software start chosen, the start bit begins conversion.
// - scan mode converts inputs zero up to the chosen last (one at least), in turn.
// - select mode converts the chosen input again and again.
// - mode and run or stop come from the mode register fields.
// - the done request pulses each time a result is written.
`timescale 1ns/1ns
`include "sas_map.svh"

module sas_adc_seq #(
   parameter int CONV_CYC = `SAS_CONV_CYC,
   parameter int SAMPLE_CYC = `SAS_SAMPLE_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // converter mode register fields
   input wire sas_pkg::sas_mode_t i_mode,
   input wire logic i_sw_start,
   // hardware trigger
   input wire logic i_external_start_trigger,
   // analog side
   input wire logic i_cmp_above,
   output logic [2:0] o_analog_input_n,
   output logic [7:0] o_dac_code,
   output logic o_sampling,
   output logic o_busy,
   // result and request
   output sas_pkg::sas_result_t o_conversion_result_reg,
   output logic o_conversion_done_irq
);
   import sas_pkg::*;

   localparam int STEP_CYC = (CONV_CYC - SAMPLE_CYC) / 8;
   localparam int CNT_W = $clog2(CONV_CYC + 1);

   ////////////////////////////////////////////////////////////////
   // elaboration checks
   generate
      if (SAMPLE_CYC < 1 || STEP_CYC < 2) begin : g_bad_time
         $error("sas_adc_seq: phase lengths too short");
      end
      if ((CONV_CYC - SAMPLE_CYC) % 8 != 0) begin : g_bad_split
         $error("sas_adc_seq: step time must split evenly");
      end
   endgenerate

   // one-hot mask for a bit index, used for trial and clear
   function automatic logic [7:0] sas_bit_mask(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction

   ////////////////////////////////////////////////////////////////
   // state
   sas_state_t st_reg, st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] sar_reg, sar_next;
   logic [2:0] chan_reg, chan_next;
   logic [2:0] last_reg, last_next;
   logic scan_reg, scan_next;
   logic trig_reg;
   sas_result_t res_reg, res_next;
   logic irq_reg, irq_next;

   logic trig_rise;
   logic start;
   logic phase_end;
   logic [7:0] decided;
   logic [2:0] scan_last;

   // trigger edge and start decode
   always_comb begin
      trig_rise = i_external_start_trigger && !trig_reg;
      start = i_mode.run && (i_mode.hw_start ? trig_rise : i_sw_start);
      phase_end = (cnt_reg == '0);
      // comparator high keeps the trial bit
      decided = i_cmp_above ? sar_reg : (sar_reg & ~sas_bit_mask(bit_reg));
      // scan needs at least two inputs, so zero widens to one
      scan_last = (i_mode.chan == 3'h0) ? 3'h1 : i_mode.chan;
   end

   ////////////////////////////////////////////////////////////////
   // sequencer next-state
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sar_next = sar_reg;
      chan_next = chan_reg;
      last_next = last_reg;
      scan_next = scan_reg;
      res_next = res_reg;
      irq_next = 1'b0;
      case (st_reg)
         SAS_IDLE: begin
            // starts while busy are ignored, only idle listens
            if (start) begin
               st_next = SAS_SAMPLE;
               cnt_next = CNT_W'(SAMPLE_CYC - 1);
               scan_next = i_mode.scan;
               last_next = scan_last;
               chan_next = i_mode.scan ? 3'h0 : i_mode.chan;
               sar_next = `SAS_DATA_RST;
            end
         end
         SAS_SAMPLE: begin
            if (phase_end) begin
               st_next = SAS_STEP;
               cnt_next = CNT_W'(STEP_CYC - 1);
               bit_next = `SAS_MSB_IDX;
               sar_next = `SAS_MSB_MASK;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         SAS_STEP: begin
            if (!phase_end) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (bit_reg != 3'h0) begin
               // keep decision, try next lower bit
               bit_next = bit_reg - 3'h1;
               sar_next = decided | sas_bit_mask(bit_reg - 3'h1);
               cnt_next = CNT_W'(STEP_CYC - 1);
            end else begin
               res_next.data = decided;
               res_next.chan = chan_reg;
               irq_next = 1'b1;
               // conversions repeat until run is cleared
               st_next = SAS_SAMPLE;
               cnt_next = CNT_W'(SAMPLE_CYC - 1);
               sar_next = `SAS_DATA_RST;
               if (scan_reg) begin
                  chan_next = (chan_reg == last_reg) ? 3'h0 : chan_reg + 3'h1;
               end else begin
                  chan_next = chan_reg;
               end
            end
         end
         default: begin
            st_next = SAS_IDLE;
         end
      endcase
      // clearing run aborts at once, a half result is dropped
      if (!i_mode.run) begin
         st_next = SAS_IDLE;
         if (st_reg == SAS_IDLE) begin
            irq_next = 1'b0;
         end
      end
   end

   // register stage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg <= SAS_IDLE;
         cnt_reg <= '0;
         bit_reg <= `SAS_MSB_IDX;
         sar_reg <= `SAS_DATA_RST;
         chan_reg <= `SAS_CHAN_RST;
         last_reg <= `SAS_CHAN_RST;
         scan_reg <= 1'b0;
         trig_reg <= 1'b0;
         res_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sar_reg <= sar_next;
         chan_reg <= chan_next;
         last_reg <= last_next;
         scan_reg <= scan_next;
         trig_reg <= i_external_start_trigger;
         res_reg <= res_next;
         irq_reg <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign o_analog_input_n = chan_reg;
   assign o_dac_code = sar_reg;
   assign o_sampling = (st_reg == SAS_SAMPLE);
   assign o_busy = (st_reg != SAS_IDLE);
   assign o_conversion_result_reg = res_reg;
   assign o_conversion_done_irq = irq_reg;

   ////////////////////////////////////////////////////////////////
   // checking helper: cycles since the sample phase began
   logic [CNT_W-1:0] len_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         len_reg <= '0;
      end else if (st_next == SAS_SAMPLE && st_reg != SAS_SAMPLE) begin
         len_reg <= CNT_W'(1);
      end else if (st_reg != SAS_IDLE) begin
         len_reg <= len_reg + 1'b1;
      end
   end

   property p_chan_select;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg != SAS_IDLE && !scan_reg) |-> (chan_reg == $past(chan_reg) || $past(st_reg) == SAS_IDLE);
   endproperty
   a_chan_select: assert property (p_chan_select) else $error("select channel moved");

   property p_sar_clear;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg == SAS_STEP && phase_end && !i_cmp_above && bit_reg != 3'h0 && i_mode.run)
      |=> (sar_reg & sas_bit_mask($past(bit_reg))) == 8'h00;
   endproperty
   a_sar_clear: assert property (p_sar_clear) else $error("rejected trial bit kept");

   property p_result_src;
      @(posedge i_clk) disable iff (i_rst)
      o_conversion_done_irq |-> o_conversion_result_reg.data == $past(decided);
   endproperty
   a_result_src: assert property (p_result_src) else $error("result not the decision");

   property p_conv_time;
      @(posedge i_clk) disable iff (i_rst)
      o_conversion_done_irq |-> $past(len_reg) == CNT_W'(CONV_CYC);
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

   property p_hw_start;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg == SAS_IDLE && i_mode.run && i_mode.hw_start && trig_rise) |=> o_sampling;
   endproperty
   a_hw_start: assert property (p_hw_start) else $error("trigger did not start");

   property p_sw_start;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg == SAS_IDLE && i_mode.run && !i_mode.hw_start && i_sw_start) |=> o_sampling;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("start bit did not start");

   property p_scan_step;
      @(posedge i_clk) disable iff (i_rst)
      (o_conversion_done_irq && scan_reg && o_busy) |-> chan_reg != $past(chan_reg);
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan did not advance");

   property p_select_repeat;
      @(posedge i_clk) disable iff (i_rst)
      (o_conversion_done_irq && !scan_reg && o_busy) |-> o_sampling && $stable(chan_reg);
   endproperty
   a_select_repeat: assert property (p_select_repeat) else $error("select did not repeat");

   property p_stop;
      @(posedge i_clk) disable iff (i_rst)
      !i_mode.run |=> !o_busy;
   endproperty
   a_stop: assert property (p_stop) else $error("run low but still busy");

   property p_irq_write;
      @(posedge i_clk) disable iff (i_rst)
      !o_conversion_done_irq |-> $stable(o_conversion_result_reg);
   endproperty
   a_irq_write: assert property (p_irq_write) else $error("result moved without request");

   // a stop inside the first step breaks the length count, so the check stands down
   property p_bit_order;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg == SAS_SAMPLE && phase_end && i_mode.run)
      |=> bit_reg == 3'h7 ##(STEP_CYC)
          (bit_reg == 3'h6 || len_reg != CNT_W'(SAMPLE_CYC + STEP_CYC + 1));
   endproperty
   a_bit_order: assert property (p_bit_order) else $error("bits not msb first");

   // sampling always starts from an empty trial code
   property p_dac_sample;
      @(posedge i_clk) disable iff (i_rst)
      o_sampling |-> o_dac_code == 8'h00;
   endproperty
   a_dac_sample: assert property (p_dac_sample) else $error("trial code not cleared");

   property p_res_chan;
      @(posedge i_clk) disable iff (i_rst)
      o_conversion_done_irq |-> o_conversion_result_reg.chan == $past(chan_reg);
   endproperty
   a_res_chan: assert property (p_res_chan) else $error("result channel wrong");

   // a start seen mid-step must not restart the conversion
   property p_busy_refuse;
      @(posedge i_clk) disable iff (i_rst)
      (st_reg == SAS_STEP && !phase_end && i_mode.run) |=> st_reg == SAS_STEP;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("step phase broken");

   property p_scan_wrap;
      @(posedge i_clk) disable iff (i_rst)
      (o_conversion_done_irq && scan_reg && o_busy && $past(chan_reg) == last_reg)
      |-> chan_reg == 3'h0;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

   property p_irq_pulse;
      @(posedge i_clk) disable iff (i_rst)
      o_conversion_done_irq |=> !o_conversion_done_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("done request too long");

endmodule

// ---- dv/sas_analog_model.sv ----
// Purpose: far-side model, input levels behind the multiplexer and a comparator
// Assumes: one 8-bit level per input, packed channel 0 in the low byte
// Notes: comparator settles on the falling edge, well clear of the sampling edge
`timescale 1ns/1ns

module sas_analog_model (
   // clock
   input wire logic i_clk,
   // converter side
   input wire logic [2:0] i_mux,
   input wire logic [7:0] i_dac,
   // input levels from the bench
   input wire logic [63:0] i_levels,
   // comparator
   output logic o_cmp_above
);
   ////////////////////////////////////////////////////////////////////////////
   // compare the selected level with the trial code; a half cycle of settling
   initial o_cmp_above = 1'b0;
   always @(negedge i_clk) begin
      o_cmp_above <= (i_levels[i_mux * 8 +: 8] >= i_dac);
   end
endmodule

// ---- dv/sas_adc_seq_tb.sv ----
// Purpose: self-checking bench for the sar converter sequencer
// Assumes: shortened counts, 35 cycles a conversion, 3 of them sampling
// Notes: inputs change on the falling edge, outputs are sampled there too
`timescale 1ns/1ns

module sas_adc_seq_tb;
   import sas_pkg::*;
   logic i_clk, i_rst, sw_start, trig, cmp_above, sampling, busy, irq;
   logic [2:0] mux;
   logic [7:0] dac;
   logic [63:0] levels;
   sas_mode_t mode;
   sas_result_t res;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed;

   ////////////////////////////////////////////////////////////////////////////
   // clock and a hang limit well above the run length
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         close_out();
      end
   end

   sas_adc_seq #(.CONV_CYC(35), .SAMPLE_CYC(3)) i_sas_adc_seq (
      .i_clk(i_clk), .i_rst(i_rst), .i_mode(mode), .i_sw_start(sw_start),
      .i_external_start_trigger(trig), .i_cmp_above(cmp_above),
      .o_analog_input_n(mux), .o_dac_code(dac), .o_sampling(sampling), .o_busy(busy),
      .o_conversion_result_reg(res), .o_conversion_done_irq(irq));
   sas_analog_model i_sas_analog_model (
      .i_clk(i_clk), .i_mux(mux), .i_dac(dac), .i_levels(levels), .o_cmp_above(cmp_above));

   ////////////////////////////////////////////////////////////////////////////
   // compares and expectations
   task automatic chk_flag(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic chk_val(input logic [10:0] got, input logic [10:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // scan with last channel 0 still covers two inputs
   function automatic logic [2:0] exp_chan(logic scan, logic [2:0] ch, int j);
      int last;
      last = (ch == 3'h0) ? 1 : int'(ch);
      return scan ? 3'(j % (last + 1)) : ch;
   endfunction
   // trial code at step s: bits above kept from the level, bit 7-s on trial
   function automatic logic [7:0] exp_dac(logic [7:0] lv, int s);
      return (lv & ~(8'hff >> s)) | (8'h80 >> s);
   endfunction

   // start, follow n conversions cycle by cycle, then stop mid-conversion
   task automatic run_seq(input logic hw, input logic scan, input logic [2:0] ch, input int n);
      int k, ph;
      logic [2:0] ec, pc;
      for (int i = 1; i < 7; i++) levels[i * 8 +: 8] = 8'($random(seed));
      mode = '{1'b1, hw, scan, ch};
      sw_start = 1'b1;
      if (hw) begin
         // software bit alone must not start in trigger mode
         @(negedge i_clk);
         chk_flag(busy, 1'b0, "busy soft");
         sw_start = 1'b0;
         trig = 1'b1;
      end
      for (int t = 1; t <= 35 * n + 10; t++) begin
         @(negedge i_clk);
         k = (t - 1) / 35;
         ph = (t - 1) % 35;
         // a start pulse or a trigger edge while busy must be ignored
         sw_start = (ph == 20);
         if (hw) trig = (ph != 20);
         ec = exp_chan(scan, ch, k);
         pc = exp_chan(scan, ch, k - 1);
         chk_flag(busy, 1'b1, "busy");
         chk_flag(irq, t > 1 && ph == 0, "irq");
         chk_flag(sampling, ph < 3, "sampling");
         if (t > 1 && ph == 0)
            chk_val(res, {pc, levels[pc * 8 +: 8]}, "result");
         if (ph >= 3 && (ph - 3) % 4 == 0)
            chk_val({mux, dac}, {ec, exp_dac(levels[ec * 8 +: 8], (ph - 3) / 4)}, "step");
         if (ph < 3)
            chk_val({mux, dac}, {ec, 8'h00}, "sample");
      end
      // stop drops the conversion and refuses a start, one cycle after the last stimulus
      @(negedge i_clk);
      mode.run = 1'b0;
      sw_start = 1'b1;
      repeat (40) begin
         @(negedge i_clk);
         chk_flag(busy | irq, 1'b0, "stopped");
      end
      trig = 1'b0;
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence, level 00 on input 0 and ff on input 7 as fixed corners
   initial begin
      seed = 32'h4a19_f75c;
      i_rst = 1'b1;
      sw_start = 1'b0;
      trig = 1'b0;
      mode = '0;
      levels = {8'hff, 48'h0000_0000_0000, 8'h00};
      repeat (16) @(posedge i_clk);
      @(negedge i_clk);
      chk_val(res, 11'h000, "reset result");
      chk_val({mux, dac}, 11'h000, "reset step");
      chk_flag(busy | irq | sampling, 1'b0, "reset flags");
      i_rst = 1'b0;
      run_seq(1'b0, 1'b0, 3'($random(seed)), 3);
      run_seq(1'b0, 1'b0, 3'h7, 2);
      run_seq(1'b0, 1'b1, 3'h3, 5);
      run_seq(1'b0, 1'b1, 3'h0, 3);
      run_seq(1'b1, 1'b0, 3'h0, 2);
      run_seq(1'b1, 1'b1, 3'h7, 9);
      // reset in mid-conversion clears all, then a fresh start works
      mode = '{1'b1, 1'b0, 1'b1, 3'h2};
      sw_start = 1'b1;
      repeat (20) @(negedge i_clk);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      chk_val(res, 11'h000, "mid reset result");
      chk_val({mux, dac}, 11'h000, "mid reset step");
      chk_flag(busy | irq | sampling, 1'b0, "mid reset flags");
      i_rst = 1'b0;
      run_seq(1'b0, 1'b1, 3'h2, 2);
      close_out();
   end
endmodule
